// ==== inc/pixel_demux_map.vh ====
// Constants for the double-edge pixel input demultiplexer
`ifndef PIXEL_DEMUX_MAP_VH
`define PIXEL_DEMUX_MAP_VH

`define PIN_WIDTH 12
`define CTRL_SUBADDR 8'h54
`define CTRL_SLOT_BIT 0
`define CTRL_EDGE_BIT 1
`define FMT_444_24 2'h0
`define FMT_RGB_555 2'h1
`define FMT_RGB_565 2'h2
`define FMT_422 2'h3
`define SYNC_RESET_VAL 1'b0

`endif

// ==== src/pixel_sync.v ====
// Two-flop synchroniser with asynchronous clear
`timescale 1ns/1ps
`include "pixel_demux_map.vh"

module pixel_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {WIDTH{`SYNC_RESET_VAL}};
            q <= {WIDTH{`SYNC_RESET_VAL}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // pixel_sync

// ==== src/pixel_demux.v ====
// Double-edge pixel port demultiplexer for four input formats
`timescale 1ns/1ps
`include "pixel_demux_map.vh"

// What this block does
// - 24-bit green-low half: G3..0, B7..0
// - 24-bit red half: R7..0, G7..4
// - 15-bit RGB uses pins 7..0, pin7 of red half ignored
// - 16-bit 5-6-5 RGB, six green bits
// - 4:2:2 CB, Y0, CR, Y1 over four edges
// - Each chroma pair shared by both lumas
// - Edge select picks edge of first half
// - Slot order picks which half comes first
// - Control register 54h: bit0 slot, bit1 edge
module pixel_demux (
    input wire clk,
    input wire resetn,
    input wire pixel_clock,
    input wire [`PIN_WIDTH-1:0] pixel_data_pins,
    input wire [1:0] input_format,
    input wire [7:0] input_control,
    output reg pixel_valid_r,
    output reg [7:0] red_cr_r,
    output reg [7:0] green_y_r,
    output reg [7:0] blue_cb_r
);
    wire rst_n;
    wire [`PIN_WIDTH:0] pins_sync;
    wire clk_sync;
    wire [`PIN_WIDTH-1:0] data_sync;
    reg clk_prev_r;
    reg [1:0] fmt_r;
    reg [1:0] phase_r;
    reg [`PIN_WIDTH-1:0] first_r;
    reg [7:0] cb_r;
    reg [7:0] y0_r;
    reg pend_r;
    reg y1_pend_r;
    reg [7:0] y1_r;
    reg [7:0] cr_r;
    reg [1:0] phase_nxt;
    reg [7:0] red_nxt;
    reg [7:0] green_nxt;
    reg [7:0] blue_nxt;
    reg [`PIN_WIDTH-1:0] grn_half;
    reg [`PIN_WIDTH-1:0] red_half;
    wire slot_order;
    wire first_edge_select;
    wire rise;
    wire fall;
    wire first_edge;
    wire second_edge;

    // Zero-extend a five-bit colour field
    function [7:0] zext5;
        input [4:0] v;
        begin
            zext5 = {3'h0, v};
        end
    endfunction

    // True for the two-edge formats
    function is_wide;
        input [1:0] f;
        begin
            is_wide = (f != `FMT_422);
        end
    endfunction

    // Reset release through two flops
    pixel_sync #(.WIDTH(1)) u_rst_sync (
        .clk(clk),
        .rst_n(resetn),
        .d(1'b1),
        .q(rst_n)
    );

    // Link clock and data cross together
    pixel_sync #(.WIDTH(`PIN_WIDTH + 1)) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({pixel_clock, pixel_data_pins}),
        .q(pins_sync)
    );

    assign clk_sync = pins_sync[`PIN_WIDTH];
    assign data_sync = pins_sync[`PIN_WIDTH-1:0];
    assign slot_order = input_control[`CTRL_SLOT_BIT];
    assign first_edge_select = input_control[`CTRL_EDGE_BIT];
    // Edge detect on the synchronised link clock
    assign rise = clk_sync & ~clk_prev_r;
    assign fall = ~clk_sync & clk_prev_r;
    assign first_edge = first_edge_select ? fall : rise;
    assign second_edge = first_edge_select ? rise : fall;

    // Sort the two halves by slot order
    always @* begin
        if (slot_order) begin
            red_half = first_r;
            grn_half = data_sync;
        end else begin
            grn_half = first_r;
            red_half = data_sync;
        end
    end

    // Pin assignment per format
    // Unused pins never reach the outputs
    // Narrow formats land in the low bits
    always @* begin
        red_nxt = 8'h00;
        green_nxt = 8'h00;
        blue_nxt = 8'h00;
        case (fmt_r)
            `FMT_444_24: begin
                blue_nxt = grn_half[7:0];
                green_nxt = {red_half[3:0], grn_half[11:8]};
                red_nxt = red_half[11:4];
            end
            `FMT_RGB_555: begin
                blue_nxt = zext5(grn_half[4:0]);
                green_nxt = zext5({red_half[1:0], grn_half[7:5]});
                red_nxt = zext5(red_half[6:2]);
            end
            `FMT_RGB_565: begin
                blue_nxt = zext5(grn_half[4:0]);
                green_nxt = {2'h0, red_half[2:0], grn_half[7:5]};
                red_nxt = zext5(red_half[7:3]);
            end
            default: begin
                red_nxt = 8'h00;
                green_nxt = 8'h00;
                blue_nxt = 8'h00;
            end
        endcase
    end

    // Half-word phase; four slots in 4:2:2
    always @* begin
        phase_nxt = phase_r;
        if (!is_wide(fmt_r)) begin
            if ((phase_r[0] == 1'b0 && first_edge) || (phase_r[0] && second_edge)) begin
                phase_nxt = phase_r + 2'h1;
            end
        end else begin
            if (phase_r == 2'h0 && first_edge) begin
                phase_nxt = 2'h1;
            end else if (phase_r == 2'h1 && second_edge) begin
                phase_nxt = 2'h0;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_r <= 1'b0;
            fmt_r <= `FMT_444_24;
            phase_r <= 2'h0;
            first_r <= {`PIN_WIDTH{1'b0}};
            cb_r <= 8'h00;
            y0_r <= 8'h00;
            y1_r <= 8'h00;
            cr_r <= 8'h00;
            pend_r <= 1'b0;
            y1_pend_r <= 1'b0;
            pixel_valid_r <= 1'b0;
            red_cr_r <= 8'h00;
            green_y_r <= 8'h00;
            blue_cb_r <= 8'h00;
        end else begin
            clk_prev_r <= clk_sync;
            // Registered format keeps the decode glitch free
            fmt_r <= input_format;
            pixel_valid_r <= 1'b0;
            pend_r <= 1'b0;
            y1_pend_r <= pend_r;
            // Format change restarts framing; that edge is lost
            if (input_format != fmt_r) begin
                phase_r <= 2'h0;
            end else begin
                phase_r <= phase_nxt;
            end
            if (is_wide(fmt_r)) begin
                // First half held until its partner arrives
                if (phase_r == 2'h0 && first_edge) begin
                    first_r <= data_sync;
                end else if (phase_r == 2'h1 && second_edge) begin
                    pixel_valid_r <= 1'b1;
                    red_cr_r <= red_nxt;
                    green_y_r <= green_nxt;
                    blue_cb_r <= blue_nxt;
                end
            end else if (phase_nxt != phase_r) begin
                // Slot order swaps chroma and luma within each edge pair
                case ({phase_r[0] ^ slot_order, phase_r[1]})
                    2'b00: cb_r <= data_sync[7:0];
                    2'b10: y0_r <= data_sync[7:0];
                    2'b01: cr_r <= data_sync[7:0];
                    default: y1_r <= data_sync[7:0];
                endcase
                if (phase_r == 2'h3) begin
                    pend_r <= 1'b1;
                end
            end
            // Chroma and first luma go out one cycle after slot 3
            if (pend_r) begin
                pixel_valid_r <= 1'b1;
                red_cr_r <= cr_r;
                green_y_r <= y0_r;
                blue_cb_r <= cb_r;
            end
            // Second pixel of the pair reuses the chroma
            if (y1_pend_r) begin
                pixel_valid_r <= 1'b1;
                green_y_r <= y1_r;
            end
        end
    end
endmodule // pixel_demux

// ==== testbench/pixel_source.sv ====
// Graphics controller model driving double-edged pixel data
`timescale 1ns/1ps
module pixel_source (
    output logic pixel_clock,
    output logic [11:0] pixel_data_pins
);
    initial begin
        pixel_clock = 1'b0;
        pixel_data_pins = 12'h000;
    end
    // Clock rests at the level the second edge leaves
    task automatic park(input logic lvl);
        pixel_clock = lvl;
    endtask
    task automatic frame(input logic [47:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            pixel_data_pins = w[12*i +: 12];
            #16 pixel_clock = ~pixel_clock;
            #12;
        end
        // Idle bus shows the inverse after the frame
        pixel_data_pins = ~pixel_data_pins;
        #4;
    endtask
endmodule // pixel_source

// ==== testbench/pixel_demux_properties.sv ====
// Port assertions for the pixel demultiplexer
`timescale 1ns/1ps
module pixel_demux_properties (
    input wire clk,
    input wire resetn,
    input wire pixel_clock,
    input wire [11:0] pixel_data_pins,
    input wire [1:0] input_format,
    input wire [7:0] input_control,
    input wire pixel_valid_r,
    input wire [7:0] red_cr_r,
    input wire [7:0] green_y_r,
    input wire [7:0] blue_cb_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire wide = input_format != 2'h3;
    sequence pair_s;
        pixel_valid_r ##1 pixel_valid_r ##1 !pixel_valid_r;
    endsequence
    AST_PULSE: assert property (pixel_valid_r && wide |=> !pixel_valid_r)
        else $error("valid longer than one cycle");
    AST_GAP: assert property ($fell(pixel_valid_r) && wide |-> !pixel_valid_r [*8])
        else $error("pixels too close");
    AST_EDGE: assert property (pixel_valid_r && wide |-> $past(pixel_clock, 3) == input_control[1])
        else $error("pixel not on second edge");
    AST_HOLD: assert property (!pixel_valid_r |-> $stable({red_cr_r, green_y_r, blue_cb_r}))
        else $error("pixel changed without valid");
    AST_NARROW15: assert property (pixel_valid_r && input_format == 2'h1 |->
        {red_cr_r[7:5], green_y_r[7:5], blue_cb_r[7:5]} == 9'h000) else $error("15-bit high bits");
    AST_NARROW16: assert property (pixel_valid_r && input_format == 2'h2 |->
        {red_cr_r[7:5], green_y_r[7:6], blue_cb_r[7:5]} == 8'h00) else $error("16-bit high bits");
    AST_PAIR: assert property ($rose(pixel_valid_r) && !wide |-> pair_s)
        else $error("4:2:2 pixels not paired");
    AST_CHROMA: assert property ($rose(pixel_valid_r) && !wide |=> $stable({red_cr_r, blue_cb_r}))
        else $error("chroma not shared");
endmodule // pixel_demux_properties
bind pixel_demux pixel_demux_properties i_pixel_demux_properties (.clk(clk), .resetn(resetn),
    .pixel_clock(pixel_clock), .pixel_data_pins(pixel_data_pins), .input_format(input_format),
    .input_control(input_control), .pixel_valid_r(pixel_valid_r), .red_cr_r(red_cr_r),
    .green_y_r(green_y_r), .blue_cb_r(blue_cb_r));

// ==== testbench/pixel_demux_tb.sv ====
// Self-checking bench for the pixel demultiplexer
`timescale 1ns/1ps
`include "pixel_demux_map.vh"
module pixel_demux_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] input_format = `FMT_444_24;
    logic [7:0] input_control = 8'h00;
    logic pixel_clock;
    logic [`PIN_WIDTH-1:0] pixel_data_pins;
    logic pixel_valid_r;
    logic [7:0] red_cr_r, green_y_r, blue_cb_r;
    logic [23:0] exp_q[$];
    int num_errors = 0;
    int check_count = 0;
    always #2.5 clk = ~clk;
    pixel_source i_pixel_source (.pixel_clock(pixel_clock), .pixel_data_pins(pixel_data_pins));
    pixel_demux i_pixel_demux (.clk(clk), .resetn(resetn), .pixel_clock(pixel_clock),
        .pixel_data_pins(pixel_data_pins), .input_format(input_format),
        .input_control(input_control), .pixel_valid_r(pixel_valid_r), .red_cr_r(red_cr_r),
        .green_y_r(green_y_r), .blue_cb_r(blue_cb_r));
    always @(posedge clk) begin
        if (pixel_valid_r === 1'b1) begin
            automatic logic [23:0] e = (exp_q.size() > 0) ? exp_q.pop_front() : 24'hxx_xxxx;
            check_count++;
            if ({red_cr_r, green_y_r, blue_cb_r} !== e) begin
                num_errors++;
                $display("unexpected pixel: expected %h seen %h", e, {red_cr_r, green_y_r, blue_cb_r});
            end
        end
    end
    task automatic run(input logic [1:0] fmt, input logic [1:0] ctl);
        logic [31:0] x;
        logic [7:0] r, g, b;
        logic [11:0] gh, rh;
        x = $urandom;
        @(posedge clk);
        input_control <= {x[5:0], ctl};
        input_format <= ~fmt;
        i_pixel_source.park(ctl[1]);
        repeat (8) @(posedge clk);
        input_format <= fmt;
        repeat (8) @(posedge clk);
        for (int p = 0; p < ((fmt == 2'h3) ? 1 : 2); p++) begin
            {x, r, g, b} = {$urandom, $urandom};
            gh = (fmt == 2'h0) ? {g[3:0], b} : {x[3:0], g[2:0], b[4:0]};
            rh = (fmt == 2'h0) ? {r, g[7:4]} : (fmt == 2'h1) ? {x[7:3], r[4:0], g[4:3]}
                : {x[7:4], r[4:0], g[5:3]};
            case (fmt)
                2'h0: exp_q.push_back({r, g, b});
                2'h1: exp_q.push_back({3'h0, r[4:0], 3'h0, g[4:0], 3'h0, b[4:0]});
                2'h2: exp_q.push_back({3'h0, r[4:0], 2'h0, g[5:0], 3'h0, b[4:0]});
                default: exp_q.push_back({r, g, b});
            endcase
            if (fmt == 2'h3) begin
                exp_q.push_back({r, x[15:8], b});
                i_pixel_source.frame(ctl[0] ? {x[31:28], r, x[27:24], x[15:8], x[23:20], b,
                    x[19:16], g} : {x[31:28], x[15:8], x[27:24], r, x[23:20], g, x[19:16], b}, 4);
            end else
                i_pixel_source.frame(ctl[0] ? {24'h00_0000, gh, rh} : {24'h00_0000, rh, gh}, 2);
        end
        for (int k = 0; k < 40 && exp_q.size() > 0; k++) @(posedge clk);
        check_count++;
        if (exp_q.size() != 0) begin
            num_errors++;
            $display("unexpected pixel count: expected 0 left seen %0d", exp_q.size());
        end
        $display("test format %0d control %0d done", fmt, ctl);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        void'($urandom(47429));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (8) @(posedge clk);
        for (int f = 0; f < 4; f++)
            for (int c = 0; c < 4; c++)
                run(f[1:0], c[1:0]);
        print_verdict();
    end
    initial begin
        #30000;
        num_errors++;
        print_verdict();
    end
endmodule // pixel_demux_tb
